// [design/sec_scan_counters.sv]
// Contract
// RULE1 - Edge counter adds one per rising input
// RULE2 - Reset input held on forces zero
// RULE3 - Keeps counting past preset, saturates 9999
// RULE4 - At ceiling value holds until reset
// RULE5 - Status on when value at least preset
// RULE6 - Current value at word index plus 1000
// RULE7 - Counter n maps to status bit n
// RULE8 - Preset is BCD constant 0 to 9999
// RULE9 - Reset clears status and zeroes value
// RULE10 - Stage counter single input counts rises
// RULE11 - Stage counter holds until reset command
// RULE12 - Stage status sticky; reset command clears both
// RULE13 - Input must be stable one scan first
// RULE14 - Timer pauses and resumes keeping value
// RULE15 - Timer reset clears status and value
// RULE16 - Timer eight digits span two words
// RULE17 - Edge compares this scan with previous
// RULE18 - Values held as four-digit BCD
//
// Our own choices: the Wishbone interface to the registers and the address map.
module sec_scan_counters
   import sec_pkg::*;
#(
   parameter int SCAN_DIV  = SCAN_CYCLES,   // Cycles per scan
   parameter int TENTH_DIV = TENTH_CYCLES   // Cycles per timer tick
) (
   input  wire logic                clk,             // 250 MHz clock
   input  wire logic                rst_n,           // Synchronous reset
   input  wire logic                wb_cyc_i,        // Bus cycle
   input  wire logic                wb_stb_i,        // Bus strobe
   input  wire logic                wb_we_i,         // Write enable
   input  wire logic [11:0]         wb_adr_i,        // Byte address
   input  wire logic [3:0]          wb_sel_i,        // Byte lanes
   input  wire logic [31:0]         wb_dat_i,        // Write data
   output logic      [31:0]         wb_dat_o,        // Read data
   output logic                     wb_ack_o,        // Acknowledge
   output logic                     irq,             // Level interrupt
   input  wire logic [N_EDGE-1:0]   edge_count_in,   // Edge counter inputs
   input  wire logic [N_EDGE-1:0]   edge_reset_in,   // Edge counter resets
   input  wire logic [N_STAGE-1:0]  stage_count_in,  // Stage counter inputs
   input  wire logic                timer_enable_in, // Timer enable
   input  wire logic                timer_reset_in,  // Timer reset
   output logic      [N_CT-1:0]     ct_status_out,   // Counter status bits
   output logic                     timer_status_out // Timer status bit
);

   // Input synchronisers
   logic [N_PINS-1:0] pin_meta;
   logic [N_PINS-1:0] pin_sync;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= {timer_reset_in, timer_enable_in, stage_count_in,
                      edge_reset_in, edge_count_in};
         pin_sync <= pin_meta;
      end
   end

   wire logic [N_EDGE-1:0]  edge_cnt_s  = pin_sync[N_EDGE-1:0];
   wire logic [N_EDGE-1:0]  edge_rst_s  = pin_sync[2*N_EDGE-1:N_EDGE];
   wire logic [N_STAGE-1:0] stage_cnt_s = pin_sync[2*N_EDGE+N_STAGE-1:2*N_EDGE];
   wire logic               tmr_en_s    = pin_sync[N_PINS-2];
   wire logic               tmr_rst_s   = pin_sync[N_PINS-1];

   // Registers written by software; irq_status is set by status edges and cleared by reading
   logic [31:0] ctrl;
   logic [15:0] ct_preset [N_CT];
   logic [31:0] tmr_preset;
   logic [N_STAGE-1:0] stage_pend;
   logic [N_CT:0] irq_status;
   logic [N_CT:0] irq_mask;

   wire logic run = ctrl[CTRL_RUN_BIT];

   // Scan and tenth-second dividers; stopping the scan freezes counters
   logic [31:0] scan_cnt;
   logic [31:0] tenth_cnt;
   logic        scan_tick;
   logic        tenth_tick;

   wire logic scan_wrap  = (scan_cnt == 32'(SCAN_DIV - 1));
   wire logic tenth_wrap = (tenth_cnt == 32'(TENTH_DIV - 1));

   always_ff @(posedge clk) begin
      if (!rst_n || !run) begin
         scan_cnt  <= 32'h0000_0000;
         scan_tick <= 1'b0;
      end else begin
         scan_cnt  <= scan_wrap ? 32'h0000_0000 : scan_cnt + 32'h0000_0001;
         scan_tick <= scan_wrap;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || !run) begin
         tenth_cnt  <= 32'h0000_0000;
         tenth_tick <= 1'b0;
      end else begin
         tenth_cnt  <= tenth_wrap ? 32'h0000_0000 : tenth_cnt + 32'h0000_0001;
         tenth_tick <= tenth_wrap;
      end
   end

   // Counters: indices below N_EDGE are edge counters, the rest stage counters
   logic [15:0]     ct_value [N_CT];
   logic [N_CT-1:0] ct_status;

   genvar gi;
   generate
      for (gi = 0; gi < N_CT; gi++) begin : g_ct
         if (gi < N_EDGE) begin : g_edge
            sec_bcd_counter #(.STICKY(1'b0)) u_ct (
               .clk       (clk),
               .rst_n     (rst_n),
               .scan_tick (scan_tick),
               .count_in  (edge_cnt_s[gi]),
               .clear     (edge_rst_s[gi]),  // RULE2
               .preset    (ct_preset[gi]),
               .value     (ct_value[gi]),
               .status    (ct_status[gi])  // RULE7
            );
         end else begin : g_stage
            sec_bcd_counter #(.STICKY(1'b1)) u_ct (
               .clk       (clk),
               .rst_n     (rst_n),
               .scan_tick (scan_tick),
               .count_in  (stage_cnt_s[gi-N_EDGE]),
               .clear     (stage_pend[gi-N_EDGE]),  // RULE11
               .preset    (ct_preset[gi]),
               .value     (ct_value[gi]),
               .status    (ct_status[gi])  // RULE7
            );
         end
      end
   endgenerate

   logic [31:0] tmr_value;
   logic        tmr_status;

   sec_acc_timer u_tmr (
      .clk        (clk),
      .rst_n      (rst_n),
      .tenth_tick (tenth_tick),
      .enable     (tmr_en_s),
      .reset      (tmr_rst_s),
      .preset     (tmr_preset),
      .value      (tmr_value),
      .status     (tmr_status)
   );

   assign ct_status_out    = ct_status;
   assign timer_status_out = tmr_status;

   // Wishbone decode
   wire logic [9:0] idx   = wb_adr_i[11:2];
   wire logic       req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire logic       wr    = req & wb_we_i;
   wire logic       rd    = req & ~wb_we_i;
   wire logic [31:0] lane = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   wire logic       hit_cv     = (idx[9:3] == IDX_CT_CV_BASE[9:3]);  // RULE6
   wire logic       hit_preset = (idx[9:3] == IDX_CT_PRESET[9:3]);
   wire logic [2:0] sub        = idx[2:0];
   wire logic       wr_ctrl    = wr & (idx == IDX_CTRL);
   wire logic       wr_tpre_lo = wr & (idx == IDX_TMR_PRE_LO);
   wire logic       wr_tpre_hi = wr & (idx == IDX_TMR_PRE_HI);
   wire logic       wr_stage   = wr & (idx == IDX_STAGE_RST);
   wire logic       wr_mask    = wr & (idx == IDX_IRQ_MASK);
   wire logic       rd_irq     = rd & (idx == IDX_IRQ_STATUS);

   wire logic [31:0] merged = (wb_dat_i & lane);

   // Read selection; unmapped words read zero
   wire logic [31:0] rd_word =
      hit_cv                    ? {16'h0000, ct_value[sub]} :  // RULE6
      hit_preset                ? {16'h0000, ct_preset[sub]} :
      (idx == IDX_TMR_CV_LO)    ? {16'h0000, tmr_value[15:0]} :  // RULE16
      (idx == IDX_TMR_CV_HI)    ? {16'h0000, tmr_value[31:16]} :  // RULE16
      (idx == IDX_CTRL)         ? ctrl :
      (idx == IDX_TMR_PRE_LO)   ? {16'h0000, tmr_preset[15:0]} :
      (idx == IDX_TMR_PRE_HI)   ? {16'h0000, tmr_preset[31:16]} :
      (idx == IDX_STAGE_RST)    ? {{(32-N_STAGE){1'b0}}, stage_pend} :
      (idx == IDX_CT_STATUS)    ? {{(32-N_CT){1'b0}}, ct_status} :  // RULE7
      (idx == IDX_TMR_STATUS)   ? {31'h0000_0000, tmr_status} :
      (idx == IDX_IRQ_STATUS)   ? {{(31-N_CT){1'b0}}, irq_status} :
      (idx == IDX_IRQ_MASK)     ? {{(31-N_CT){1'b0}}, irq_mask} :
      32'h0000_0000;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? rd_word : wb_dat_o;
      end
   end

   // Writable registers; byte lanes outside 16-bit words are dropped
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl <= {31'h0000_0000, merged[CTRL_RUN_BIT] | (ctrl[CTRL_RUN_BIT] & ~lane[0])};
      end
   end

   generate
      for (gi = 0; gi < N_CT; gi++) begin : g_pre
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               ct_preset[gi] <= CT_PRESET_RESET;
            end else if (wr && hit_preset && sub == 3'(gi)) begin
               // Software must write valid BCD digits only
               ct_preset[gi] <= merged[15:0] | (ct_preset[gi] & ~lane[15:0]);  // RULE8
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tmr_preset <= TMR_PRESET_RESET;
      end else if (wr_tpre_lo) begin
         tmr_preset[15:0] <= merged[15:0] | (tmr_preset[15:0] & ~lane[15:0]);
      end else if (wr_tpre_hi) begin
         tmr_preset[31:16] <= merged[15:0] | (tmr_preset[31:16] & ~lane[15:0]);  // RULE16
      end
   end

   // Reset commands wait for the next scan so the counter applies them once
   wire logic [N_STAGE-1:0] stage_req = wr_stage ? merged[N_STAGE-1:0] : '0;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stage_pend <= '0;
      end else begin
         stage_pend <= (stage_pend & ~{N_STAGE{scan_tick}}) | stage_req;  // RULE11 RULE12
      end
   end

   // Interrupts: rising status edges, cleared by reading, set wins
   logic [N_CT:0] status_prev;

   wire logic [N_CT:0] status_now = {tmr_status, ct_status};
   wire logic [N_CT:0] evt        = status_now & ~status_prev;
   wire logic [N_CT:0] rd_clear   = rd_irq ? '1 : '0;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status_prev <= '0;
         irq_status  <= '0;
      end else begin
         status_prev <= status_now;
         irq_status  <= (irq_status & ~rd_clear) | evt;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_mask <= '0;
      end else if (wr_mask) begin
         irq_mask <= merged[N_CT:0] | (irq_mask & ~lane[N_CT:0]);
      end
   end

   assign irq = |(irq_status & irq_mask);

endmodule // sec_scan_counters

// [design/sec_pkg.sv]
package sec_pkg;

   // Clock and time base
   localparam int CLK_MHZ         = 250;
   localparam int SCAN_PERIOD_US  = 1000;
   localparam int SCAN_CYCLES     = SCAN_PERIOD_US * CLK_MHZ;
   localparam int TENTH_PERIOD_MS = 100;
   localparam int TENTH_CYCLES    = TENTH_PERIOD_MS * 1000 * CLK_MHZ;

   // Counter population: edge counters first, stage counters after them
   localparam int N_EDGE  = 4;
   localparam int N_STAGE = 4;
   localparam int N_CT    = N_EDGE + N_STAGE;
   localparam int N_PINS  = 2 * N_EDGE + N_STAGE + 2;

   // Word indices; byte address is four times the index
   localparam logic [9:0] IDX_TMR_CV_LO  = 10'h000;
   localparam logic [9:0] IDX_TMR_CV_HI  = 10'h001;
   localparam logic [9:0] IDX_CTRL       = 10'h020;
   localparam logic [9:0] IDX_CT_PRESET  = 10'h040;
   localparam logic [9:0] IDX_TMR_PRE_LO = 10'h050;
   localparam logic [9:0] IDX_TMR_PRE_HI = 10'h051;
   localparam logic [9:0] IDX_STAGE_RST  = 10'h058;
   localparam logic [9:0] IDX_CT_STATUS  = 10'h060;
   localparam logic [9:0] IDX_TMR_STATUS = 10'h061;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'h068;
   localparam logic [9:0] IDX_IRQ_MASK   = 10'h069;
   localparam logic [9:0] IDX_CT_CV_BASE = 10'h200;  // Octal 1000

   // Fields and reset values
   localparam int          CTRL_RUN_BIT     = 0;
   localparam logic [31:0] CTRL_RESET       = 32'h0000_0001;
   localparam logic [15:0] CT_PRESET_RESET  = 16'h9999;
   localparam logic [31:0] TMR_PRESET_RESET = 32'h9999_9999;
   localparam logic [15:0] CT_CV_MAX        = 16'h9999;
   localparam logic [31:0] TMR_CV_MAX       = 32'h9999_9999;

   // Decimal increment of packed BCD digits
   function automatic logic [31:0] sec_bcd_inc(input logic [31:0] v);
      logic [31:0] r;
      logic        carry;
      r     = v;
      carry = 1'b1;
      for (int d = 0; d < 8; d++) begin
         if (carry) begin
            if (v[4*d +: 4] == 4'h9) begin
               r[4*d +: 4] = 4'h0;
            end else begin
               r[4*d +: 4] = v[4*d +: 4] + 4'h1;
               carry       = 1'b0;
            end
         end
      end
      return r;
   endfunction

endpackage

// [design/sec_bcd_counter.sv]
module sec_bcd_counter
   import sec_pkg::*;
#(
   parameter bit STICKY = 1'b0
) (
   input  wire logic        clk,        // System clock
   input  wire logic        rst_n,      // Synchronous reset
   input  wire logic        scan_tick,  // One pulse per scan
   input  wire logic        count_in,   // Synchronised count input
   input  wire logic        clear,      // Reset level or reset command
   input  wire logic [15:0] preset,     // BCD preset
   output logic      [15:0] value,      // BCD current value
   output logic             status      // Preset reached
);

   logic        prev_in;
   logic [15:0] next_value;
   logic        next_status;

   wire logic        rise     = count_in & ~prev_in;  // RULE17
   wire logic [31:0] inc_wide = sec_bcd_inc({16'h0000, value});  // RULE18
   wire logic        at_max   = (value == CT_CV_MAX);  // RULE3
   wire logic        meets    = (value >= preset);  // RULE5

   always_comb begin
      next_value = value;
      if (clear) begin
         next_value = 16'h0000;  // RULE2 RULE9 RULE11
      end else if (rise && !at_max) begin
         next_value = inc_wide[15:0];  // RULE1 RULE10 RULE4
      end
   end

   // Stage variant latches the flag; only a reset drops it
   assign next_status = clear ? 1'b0 : (meets | (STICKY & status));  // RULE12

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prev_in <= 1'b0;
         value   <= 16'h0000;
      end else if (scan_tick) begin
         prev_in <= count_in;  // RULE17 RULE13
         value   <= next_value;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status <= 1'b0;
      end else if (scan_tick) begin
         status <= next_status;  // RULE5
      end
   end

endmodule // sec_bcd_counter

// [design/sec_acc_timer.sv]
module sec_acc_timer
   import sec_pkg::*;
(
   input  wire logic        clk,         // System clock
   input  wire logic        rst_n,       // Synchronous reset
   input  wire logic        tenth_tick,  // One pulse per tenth second
   input  wire logic        enable,      // Synchronised enable
   input  wire logic        reset,       // Synchronised reset
   input  wire logic [31:0] preset,      // Eight-digit BCD preset
   output logic      [31:0] value,       // Eight-digit BCD value
   output logic             status       // Preset reached
);

   wire logic [31:0] inc_value = sec_bcd_inc(value);
   wire logic        advance   = tenth_tick & enable & (value != TMR_CV_MAX);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         value <= 32'h0000_0000;
      end else if (reset) begin
         value <= 32'h0000_0000;  // RULE15
      end else if (advance) begin
         value <= inc_value;  // RULE14
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status <= 1'b0;
      end else begin
         status <= !reset && (value >= preset);  // RULE15
      end
   end

endmodule // sec_acc_timer

// [tb/sec_scan_monitor.sv]
module sec_scan_monitor
   import sec_pkg::*;
#(
   parameter int SCAN_DIV = 8  // Cycles per scan
) (
   input wire logic               clk,              // Clock
   input wire logic               rst_n,            // Reset
   input wire logic               wb_cyc_i,         // Cycle
   input wire logic               wb_stb_i,         // Strobe
   input wire logic               wb_we_i,          // Write
   input wire logic [11:0]        wb_adr_i,         // Address
   input wire logic [31:0]        wb_dat_o,         // Read data
   input wire logic               wb_ack_o,         // Acknowledge
   input wire logic               irq,              // Interrupt
   input wire logic [N_EDGE-1:0]  edge_reset_in,    // Edge resets
   input wire logic               timer_reset_in,   // Timer reset
   input wire logic [N_CT-1:0]    ct_status_out,    // Counter status
   input wire logic               timer_status_out  // Timer status
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned rst_hold;
   int unsigned since_cmd;
   wire         req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire         stage_cmd = wb_ack_o && wb_we_i && wb_adr_i[11:2] == IDX_STAGE_RST;
   // Counters saturate so a long run cannot wrap into a false pass
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rst_hold  <= 0;
         since_cmd <= 1000;
      end else begin
         rst_hold  <= edge_reset_in[0] ? (rst_hold < 1000 ? rst_hold + 1 : rst_hold) : 0;
         since_cmd <= stage_cmd ? 0 : (since_cmd < 1000 ? since_cmd + 1 : since_cmd);
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_latency: assert property (req |=> wb_ack_o)
      else $error("ack not one cycle after request");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_read_hold: assert property (!req |=> $stable(wb_dat_o))
      else $error("read data moved without request");
   a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i[11:10] == 2'b11 |=> wb_dat_o == '0)
      else $error("unmapped read not zero");
   a_reset_clear: assert property ($rose(rst_n) |-> ct_status_out == '0 && !timer_status_out && !irq)
      else $error("status not clear after reset");
   a_edge_reset_hold: assert property (rst_hold > 3 * SCAN_DIV + 2 |-> !ct_status_out[0])
      else $error("status on while reset held");
   a_stage_sticky: assert property ((|($past(ct_status_out[N_CT-1:N_EDGE]) & ~ct_status_out[N_CT-1:N_EDGE])) |-> since_cmd <= 2 * SCAN_DIV + 4)
      else $error("stage status fell without command");
   a_timer_reset: assert property (timer_reset_in [*6] |-> !timer_status_out)
      else $error("timer status on during reset");
   a_irq_clear: assert property ($fell(irq) |-> wb_ack_o)
      else $error("irq fell without bus access");
endmodule // sec_scan_monitor
bind sec_scan_counters sec_scan_monitor #(.SCAN_DIV(SCAN_DIV)) mon (.clk, .rst_n, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .irq, .edge_reset_in, .timer_reset_in,
   .ct_status_out, .timer_status_out);

// [tb/sec_ladder_model.sv]
module sec_ladder_model
   import sec_pkg::*;
#(
   parameter int SCAN_DIV = 8  // Cycles per scan
) (
   input  wire logic               clk,              // Clock
   output logic      [N_EDGE-1:0]  edge_count_in,    // Edge counter inputs
   output logic      [N_EDGE-1:0]  edge_reset_in,    // Edge counter resets
   output logic      [N_STAGE-1:0] stage_count_in,   // Stage counter inputs
   output logic                    timer_enable_in,  // Timer enable
   output logic                    timer_reset_in    // Timer reset
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      edge_count_in   = '0;
      edge_reset_in   = '0;
      stage_count_in  = '0;
      timer_enable_in = 1'b0;
      timer_reset_in  = 1'b0;
   end
   // Two scans per level, so every rise is seen low then high
   task automatic pulse(input logic [N_CT-1:0] m, input int n);
      repeat (n) begin
         edge_count_in  <= m[N_EDGE-1:0];
         stage_count_in <= m[N_CT-1:N_EDGE];
         repeat (2 * SCAN_DIV) @(posedge clk);
         edge_count_in  <= '0;
         stage_count_in <= '0;
         repeat (2 * SCAN_DIV) @(posedge clk);
      end
   endtask
   task automatic rungs(input logic [N_EDGE-1:0] r, input logic en, input logic tr);
      edge_reset_in   <= r;
      timer_enable_in <= en;
      timer_reset_in  <= tr;
   endtask
endmodule // sec_ladder_model

// [tb/tb_scan_edge_counters.sv]
module tb_scan_edge_counters
   import sec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SD = 8;
   logic              clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
   logic [11:0]       wb_adr_i;
   logic [3:0]        wb_sel_i;
   logic [31:0]       wb_dat_i, wb_dat_o;
   logic [N_EDGE-1:0] edge_count_in, edge_reset_in;
   logic [3:0]        stage_count_in;
   logic              timer_enable_in, timer_reset_in, timer_status_out;
   logic [N_CT-1:0]   ct_status_out;
   logic [32:0]       exp_q[$];
   logic [32:0]       e;
   int                error_cnt = 0, check_count = 0, seed = 51, p;

   sec_scan_counters #(.SCAN_DIV(SD), .TENTH_DIV(20)) uut (.clk, .rst_n, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .edge_count_in,
      .edge_reset_in, .stage_count_in, .timer_enable_in, .timer_reset_in, .ct_status_out,
      .timer_status_out);
   sec_ladder_model #(.SCAN_DIV(SD)) lad (.clk, .edge_count_in, .edge_reset_in,
      .stage_count_in, .timer_enable_in, .timer_reset_in);

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic bus(input logic we, input logic [9:0] i, input logic [31:0] d,
                      input logic [32:0] x);
      exp_q.push_back(x);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {i, 2'b00};
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [9:0] i, input logic [31:0] x);
      bus(1'b0, i, 32'h0, {1'b1, x});
   endtask
   task automatic wr(input logic [9:0] i, input logic [31:0] d);
      bus(1'b1, i, d, 33'h0);
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Oldest note is paired with each acknowledged transfer
   always @(posedge clk) begin
      if (wb_ack_o === 1'b1) begin
         e = exp_q.size() > 0 ? exp_q.pop_front() : {1'b1, ~wb_dat_o};
         if (e[32]) check("read data", wb_dat_o, e[31:0]);
      end
   end
   initial begin
      cycles(20000);
      error_cnt++;
      end_of_test();
   end
   initial begin
      {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      p = 2 + $unsigned($random(seed)) % 4;
      cycles(4);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(IDX_CT_PRESET, 32'h9999);
      rd(IDX_CT_STATUS, 32'h0);
      rd(10'h300, 32'h0);
      wr(IDX_CT_PRESET, p);
      wr(IDX_CT_PRESET + 10'h4, p);
      wr(IDX_IRQ_MASK, 32'h1ff);
      lad.pulse(8'h11, p - 1);
      rd(IDX_CT_STATUS, 32'h0);
      lad.pulse(8'h11, 1);
      rd(IDX_CT_STATUS, 32'h11);
      check("ct status out", {24'h00_0000, ct_status_out}, 32'h0000_0011);
      rd(IDX_CT_CV_BASE, p);
      rd(IDX_CT_CV_BASE + 10'h4, p);
      check("irq", {31'h0, irq}, 32'h1);
      rd(IDX_IRQ_STATUS, 32'h11);
      rd(IDX_IRQ_STATUS, 32'h0);
      check("irq", {31'h0, irq}, 32'h0);
      lad.pulse(8'h13, 1);
      lad.pulse(8'h02, 9);
      rd(IDX_CT_CV_BASE, p + 1);
      rd(IDX_CT_CV_BASE + 10'h1, 32'h10);
      lad.rungs(4'h3, 1'b0, 1'b0);
      cycles(4 * SD);
      lad.pulse(8'h11, 1);
      rd(IDX_CT_CV_BASE, 32'h0);
      rd(IDX_CT_CV_BASE + 10'h1, 32'h0);
      rd(IDX_CT_CV_BASE + 10'h4, p + 2);
      rd(IDX_CT_STATUS, 32'h10);
      check("ct status out", {24'h00_0000, ct_status_out}, 32'h0000_0010);
      lad.rungs(4'h0, 1'b0, 1'b0);
      wr(IDX_STAGE_RST, 32'h1);
      cycles(3 * SD);
      rd(IDX_CT_CV_BASE + 10'h4, 32'h0);
      rd(IDX_CT_STATUS, 32'h0);
      wr(IDX_TMR_PRE_LO, 32'h8);
      wr(IDX_TMR_PRE_HI, 32'h0);
      wr(IDX_IRQ_MASK, 32'hff);
      lad.rungs(4'h0, 1'b1, 1'b0);
      cycles(100);
      lad.rungs(4'h0, 1'b0, 1'b0);
      cycles(210);
      check("timer status", {31'h0, timer_status_out}, 32'h0);
      lad.rungs(4'h0, 1'b1, 1'b0);
      cycles(100);
      lad.rungs(4'h0, 1'b0, 1'b0);
      cycles(10);
      check("timer status", {31'h0, timer_status_out}, 32'h1);
      rd(IDX_TMR_CV_HI, 32'h0);
      check("irq", {31'h0, irq}, 32'h0);
      rd(IDX_IRQ_STATUS, 32'h100);
      lad.rungs(4'h0, 1'b0, 1'b1);
      cycles(10);
      check("timer status", {31'h0, timer_status_out}, 32'h0);
      rd(IDX_TMR_CV_LO, 32'h0);
      lad.rungs(4'h0, 1'b0, 1'b0);
      end_of_test();
   end
endmodule // tb_scan_edge_counters
